// File: pkg/sclkp_pkg.sv
package sclkp_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_TRIM = 4'h0;
  localparam logic [3:0] ADDR_DIV  = 4'h4;
  localparam logic [3:0] ADDR_CMD  = 4'h8;
  localparam logic [3:0] ADDR_SRC  = 4'hc;

  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int         UNLOCK_BIT   = 7;
  localparam int         READY_BIT    = 4;
  localparam int         SUT_LSB      = 4;
  localparam logic [7:0] UNLOCK_ONLY  = 8'h80;
  localparam logic [7:0] DIV_RD_MASK  = 8'h8f;
  localparam logic [7:0] CMD_RD_MASK  = 8'h9f;
  localparam logic [7:0] SRC_RD_MASK  = 8'h7f;
  localparam logic [3:0] DIV_MAX      = 4'h8;
  localparam logic [3:0] DIV_FUSE_OFF = 4'h0;
  localparam logic [3:0] DIV_FUSE_ON  = 4'h3;
  localparam logic [2:0] UNLOCK_CYC   = 3'h4;
  localparam logic [7:0] CMD_RESET    = 8'h00;

  // ----------------------------------------------------------------
  // Clock commands
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_NONE    = 4'h0;
  localparam logic [3:0] CMD_DISABLE = 4'h1;
  localparam logic [3:0] CMD_ENABLE  = 4'h2;
  localparam logic [3:0] CMD_AVAIL   = 4'h3;
  localparam logic [3:0] CMD_SWITCH  = 4'h4;
  localparam logic [3:0] CMD_RECOVER = 4'h5;
  localparam logic [3:0] CMD_WD_ARL  = 4'h6;
  localparam logic [3:0] CMD_CLKOUT  = 4'h7;

  // Start-up count limits in source oscillation cycles
  localparam logic [12:0] SUT_LIM0 = 13'h0040;
  localparam logic [12:0] SUT_LIM1 = 13'h0100;
  localparam logic [12:0] SUT_LIM2 = 13'h0400;
  localparam logic [12:0] SUT_LIM3 = 13'h1000;

  typedef struct packed {
    logic       read;
    logic       write;
    logic [3:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } sclkp_avm_req_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] code;
    logic [3:0] source;
    logic [1:0] startup;
    logic       clk_out;
  } sclkp_cmd_t;

endpackage

// File: logic/sclkp_top.sv
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
// Functional notes
// - Divide system clocks by 1 to 256.
// - Division change produces no glitch.
// - New rate starts after old period ends.
// - Divider counts on undivided master clock.
// - Divider unlock sets only on lone write.
// - Divider unlock clears after four cycles.
// - Division changes only through unlock sequence.
// - Reset division follows divide-by-eight fuse.
// - Unlocked division values above eight are ignored.
// - Reserved bits read as zero.
// - Factory trim loads into trim register.
// - Top trim bit selects frequency range.
// - Low trim bits tune within range.
// - Command unlock sets alone, clears later.
// - Rewriting command unlock changes nothing.
// - Enable or availability clears ready flag.
// - Ready sets only for a running clock.
// - Command codes decode; top bit means none.
// - Commands outside unlock window are ignored.
// - Availability counts source cycles to limit.
// - Disabling the running source is ignored.
module sclkp_top
  import sclkp_pkg::*;
#(
  parameter logic [6:0]  SRC_INIT = 7'h02,
  parameter logic [12:0] LIM0     = SUT_LIM0,
  parameter logic [12:0] LIM1     = SUT_LIM1,
  parameter logic [12:0] LIM2     = SUT_LIM2,
  parameter logic [12:0] LIM3     = SUT_LIM3
) (
  input  wire                       sys_clk,
  input  wire                       rstn,
  input  sclkp_pkg::sclkp_avm_req_t avs_req,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  input  wire                       divide_by_eight_fuse,
  input  wire [7:0]                 factory_trim,
  input  wire [3:0]                 running_source,
  input  wire                       source_osc,
  output logic                      div_tick,
  output logic                      div_clk,
  output logic                      trim_range_select,
  output logic [6:0]                trim_fine_value,
  output sclkp_pkg::sclkp_cmd_t     cmd_out
);
  import sclkp_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [13:0] pin_s1_reg;
  logic [13:0] pin_s2_reg;
  logic        osc_d_reg;
  always_ff @(posedge sys_clk) begin
    pin_s1_reg <= {source_osc, running_source, factory_trim,
                   divide_by_eight_fuse};
    pin_s2_reg <= pin_s1_reg;
    osc_d_reg  <= pin_s2_reg[13];
  end
  wire       fuse_s   = pin_s2_reg[0];
  wire [7:0] trim_s   = pin_s2_reg[8:1];
  wire [3:0] run_src  = pin_s2_reg[12:9];
  wire       osc_rise = pin_s2_reg[13] & ~osc_d_reg;

  // Straps are caught on the first edge after reset release
  logic strap_pend_reg;
  always_ff @(posedge sys_clk) begin
    strap_pend_reg <= ~rstn;
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave, one wait state
  // ----------------------------------------------------------------
  logic ack_reg;
  wire  req     = avs_req.read | avs_req.write;
  wire  wr_take = avs_req.write & ack_reg & avs_req.byteenable[0];
  wire  [7:0] wd = avs_req.writedata[7:0];
  wire  wr_trim = wr_take & (avs_req.address == ADDR_TRIM);
  wire  wr_div  = wr_take & (avs_req.address == ADDR_DIV);
  wire  wr_cmd  = wr_take & (avs_req.address == ADDR_CMD);
  wire  wr_src  = wr_take & (avs_req.address == ADDR_SRC);

  assign avs_waitrequest = req & ~ack_reg;

  always_ff @(posedge sys_clk) begin
    if (!rstn)
      ack_reg <= 1'b0;
    else
      ack_reg <= req & ~ack_reg;
  end

  // ----------------------------------------------------------------
  // Oscillator trim
  // ----------------------------------------------------------------
  logic [7:0] trim_reg;
  always_ff @(posedge sys_clk) begin
    if (!rstn)
      trim_reg <= 8'h00;
    else if (strap_pend_reg)
      trim_reg <= trim_s;
    else if (wr_trim)
      trim_reg <= wd;
  end
  assign trim_range_select = trim_reg[7];
  assign trim_fine_value   = trim_reg[6:0];

  // ----------------------------------------------------------------
  // Divider control and unlock window
  // ----------------------------------------------------------------
  logic [3:0] div_sel_reg;
  logic [2:0] div_win_reg;
  wire  div_unlock  = (div_win_reg != 3'h0);
  wire  div_open    = wr_div & (wd == UNLOCK_ONLY) & ~div_unlock;
  wire  div_write   = wr_div & ~wd[UNLOCK_BIT] & div_unlock;
  wire  div_legal   = (wd[3:0] <= DIV_MAX);

  always_ff @(posedge sys_clk) begin
    if (!rstn)
      div_win_reg <= 3'h0;
    else if (div_open)
      div_win_reg <= UNLOCK_CYC;
    else if (div_write)
      div_win_reg <= 3'h0;
    else if (div_unlock)
      div_win_reg <= div_win_reg - 3'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn)
      div_sel_reg <= DIV_FUSE_OFF;
    else if (strap_pend_reg)
      div_sel_reg <= fuse_s ? DIV_FUSE_ON : DIV_FUSE_OFF;
    else if (div_write && div_legal)
      div_sel_reg <= wd[3:0];
  end
  // Reserved codes never reach the register

  // ----------------------------------------------------------------
  // Prescaler counter
  // ----------------------------------------------------------------
  // Counts on every master edge; the new factor is only taken when
  // the current period wraps, so no shortened pulse ever appears.
  logic [3:0] act_sel_reg;
  logic [7:0] cnt_reg;
  logic       tick_reg;
  logic       dclk_reg;
  wire  [7:0] last = 8'((9'h1 << act_sel_reg) - 9'h1);
  wire        wrap = (cnt_reg == last);
  wire  [7:0] half = 8'((9'h1 << act_sel_reg) >> 1);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cnt_reg     <= 8'h00;
      act_sel_reg <= DIV_FUSE_OFF;
      tick_reg    <= 1'b0;
      dclk_reg    <= 1'b0;
    end else begin
      cnt_reg  <= wrap ? 8'h00 : cnt_reg + 8'h01;
      tick_reg <= wrap;
      dclk_reg <= wrap | (cnt_reg < half - 8'h01);
      if (wrap)
        act_sel_reg <= div_sel_reg;
    end
  end
  assign div_tick = tick_reg;
  assign div_clk  = (act_sel_reg == 4'h0) ? 1'b1 : dclk_reg;

  // ----------------------------------------------------------------
  // Clock command register and unlock
  // ----------------------------------------------------------------
  logic [2:0] cmd_win_reg;
  logic [3:0] cmd_code_reg;
  wire  cmd_unlock = (cmd_win_reg != 3'h0);
  wire  cmd_open   = wr_cmd & (wd == UNLOCK_ONLY) & ~cmd_unlock;
  wire  cmd_write  = wr_cmd & ~wd[UNLOCK_BIT] & cmd_unlock;
  wire  [3:0] code = wd[3] ? CMD_NONE : wd[3:0];

  always_ff @(posedge sys_clk) begin
    if (!rstn)
      cmd_win_reg <= 3'h0;
    else if (cmd_open)
      cmd_win_reg <= UNLOCK_CYC;
    else if (cmd_write)
      cmd_win_reg <= 3'h0;
    else if (cmd_unlock)
      cmd_win_reg <= cmd_win_reg - 3'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn)
      cmd_code_reg <= CMD_RESET[3:0];
    else if (cmd_write)
      cmd_code_reg <= wd[3:0];
  end

  // ----------------------------------------------------------------
  // Source selection register
  // ----------------------------------------------------------------
  logic [6:0] src_reg;
  wire  do_recover = cmd_write & (code == CMD_RECOVER);
  always_ff @(posedge sys_clk) begin
    if (!rstn)
      src_reg <= SRC_INIT;
    else if (do_recover)
      src_reg[3:0] <= run_src;
    else if (wr_src)
      src_reg <= wd[6:0];
  end

  // ----------------------------------------------------------------
  // Command issue
  // ----------------------------------------------------------------
  wire  kill_run = (code == CMD_DISABLE) & (src_reg[3:0] == run_src);
  wire  issue    = cmd_write & (code != CMD_NONE) & ~kill_run;
  wire  start_av = cmd_write & ((code == CMD_ENABLE) |
                                (code == CMD_AVAIL));
  always_ff @(posedge sys_clk) begin
    if (!rstn)
      cmd_out <= '0;
    else begin
      cmd_out.valid   <= issue;
      cmd_out.code    <= code;
      cmd_out.source  <= src_reg[3:0];
      cmd_out.startup <= src_reg[5:4];
      cmd_out.clk_out <= src_reg[6];
    end
  end

  // ----------------------------------------------------------------
  // Availability counter
  // ----------------------------------------------------------------
  typedef enum logic {AV_IDLE, AV_COUNT} sclkp_av_t;
  sclkp_av_t   av_state_reg;
  logic [12:0] av_cnt_reg;
  logic        ready_reg;

  function automatic logic [12:0] lim_of(input logic [1:0] sut);
    unique case (sut)
      2'h0: lim_of = LIM0;
      2'h1: lim_of = LIM1;
      2'h2: lim_of = LIM2;
      2'h3: lim_of = LIM3;
    endcase
  endfunction
  wire [12:0] av_lim = lim_of(src_reg[SUT_LSB+1:SUT_LSB]);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      av_state_reg <= AV_IDLE;
      av_cnt_reg   <= 13'h0000;
      ready_reg    <= 1'b0;
    end else if (start_av) begin
      av_state_reg <= AV_COUNT;
      av_cnt_reg   <= 13'h0000;
      ready_reg    <= 1'b0;
    end else begin
      unique case (av_state_reg)
        AV_IDLE: ;
        AV_COUNT:
          if (av_cnt_reg >= av_lim) begin
            av_state_reg <= AV_IDLE;
            ready_reg    <= 1'b1;
          end else if (osc_rise)
            av_cnt_reg <= av_cnt_reg + 13'h0001;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [7:0] rd_div = {div_unlock, 3'h0, div_sel_reg} & DIV_RD_MASK;
  wire [7:0] rd_cmd = {cmd_unlock, 2'h0, ready_reg, cmd_code_reg}
                      & CMD_RD_MASK;
  wire [7:0] rd_sel =
    (avs_req.address == ADDR_TRIM) ? trim_reg :
    (avs_req.address == ADDR_DIV)  ? rd_div :
    (avs_req.address == ADDR_CMD)  ? rd_cmd :
    (avs_req.address == ADDR_SRC)  ? {1'b0, src_reg} & SRC_RD_MASK :
                                     8'h00;

  always_ff @(posedge sys_clk) begin
    if (!rstn)
      avs_readdata <= 32'h0000_0000;
    else if (avs_req.read && !ack_reg)
      avs_readdata <= {24'h00_0000, rd_sel};
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_cnt_bound;
    @(posedge sys_clk) disable iff (!rstn) cnt_reg <= last;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound)
    else $error("prescaler count past its period");

  property p_sel_at_wrap;
    @(posedge sys_clk) disable iff (!rstn)
      !wrap |=> $stable(act_sel_reg);
  endproperty
  a_sel_at_wrap: assert property (p_sel_at_wrap)
    else $error("division factor changed mid period");

  property p_act_legal;
    @(posedge sys_clk) disable iff (!rstn) act_sel_reg <= DIV_MAX;
  endproperty
  a_act_legal: assert property (p_act_legal)
    else $error("reserved division factor became active");

  property p_div_open;
    @(posedge sys_clk) disable iff (!rstn)
      div_open |=> div_unlock;
  endproperty
  a_div_open: assert property (p_div_open)
    else $error("divider unlock did not set");

  sequence s_div_held;
    div_unlock && !div_write;
  endsequence
  // Untouched window: open for exactly four cycles, then closed
  property p_div_window;
    @(posedge sys_clk) disable iff (!rstn)
      $rose(div_unlock) ##0 s_div_held ##1 (!div_write)[*3]
        |-> div_unlock ##1 !div_unlock;
  endproperty
  a_div_window: assert property (p_div_window)
    else $error("divider unlock window is not four cycles");

  property p_div_close;
    @(posedge sys_clk) disable iff (!rstn)
      div_write |=> !div_unlock;
  endproperty
  a_div_close: assert property (p_div_close)
    else $error("divider unlock stayed open after division write");

  // Strap load is a legal change, so its cycle is left out
  property p_div_locked;
    @(posedge sys_clk) disable iff (!rstn)
      !div_write && !strap_pend_reg |=> $stable(div_sel_reg);
  endproperty
  a_div_locked: assert property (p_div_locked)
    else $error("division changed without unlock");

  property p_cmd_window;
    @(posedge sys_clk) disable iff (!rstn)
      $rose(cmd_unlock) ##1 !cmd_write[*3] |=> !cmd_unlock;
  endproperty
  a_cmd_window: assert property (p_cmd_window)
    else $error("command unlock outlived four cycles");

  property p_cmd_rewrite;
    @(posedge sys_clk) disable iff (!rstn)
      (wr_cmd && (wd == UNLOCK_ONLY) && cmd_unlock)
        |=> cmd_win_reg == $past(cmd_win_reg) - 3'h1;
  endproperty
  a_cmd_rewrite: assert property (p_cmd_rewrite)
    else $error("command unlock rewrite changed the window");

  property p_cmd_ignored;
    @(posedge sys_clk) disable iff (!rstn)
      (wr_cmd && !cmd_unlock) |=> !cmd_out.valid;
  endproperty
  a_cmd_ignored: assert property (p_cmd_ignored)
    else $error("command taken outside unlock window");

  property p_ready_clear;
    @(posedge sys_clk) disable iff (!rstn)
      start_av |=> !ready_reg ##1 !ready_reg;
  endproperty
  a_ready_clear: assert property (p_ready_clear)
    else $error("ready not cleared by request");

  property p_no_kill_run;
    @(posedge sys_clk) disable iff (!rstn)
      (cmd_write && kill_run) |=> !cmd_out.valid;
  endproperty
  a_no_kill_run: assert property (p_no_kill_run)
    else $error("running source disable issued");

endmodule

// File: verif/sclkp_tb_top.sv
`timescale 1ns/10ps
module sclkp_tb_top;
  import sclkp_pkg::*;

  logic           sys_clk;
  logic           rstn;
  sclkp_avm_req_t avs_req;
  logic [31:0]    avs_readdata;
  logic           avs_waitrequest;
  logic           divide_by_eight_fuse;
  logic [7:0]     factory_trim;
  logic [3:0]     running_source;
  logic           source_osc;
  logic           div_tick;
  logic           div_clk;
  logic           trim_range_select;
  logic [6:0]     trim_fine_value;
  sclkp_cmd_t     cmd_out;
  logic [31:0]    seed;
  logic [31:0]    rd;
  logic           osc_run;
  logic [3:0]     last_code;
  logic [3:0]     cur_div;
  logic [7:0]     tv [4];
  int             num_errors;
  int             total_checks;
  int             pulse_cnt;

  // Short start-up limits keep the ready wait brief
  sclkp_top #(
    .LIM0 (13'h0004),
    .LIM1 (13'h0004),
    .LIM2 (13'h0004),
    .LIM3 (13'h0004)
  ) u_sclkp_top (
    .sys_clk              (sys_clk),
    .rstn                 (rstn),
    .avs_req              (avs_req),
    .avs_readdata         (avs_readdata),
    .avs_waitrequest      (avs_waitrequest),
    .divide_by_eight_fuse (divide_by_eight_fuse),
    .factory_trim         (factory_trim),
    .running_source       (running_source),
    .source_osc           (source_osc),
    .div_tick             (div_tick),
    .div_clk              (div_clk),
    .trim_range_select    (trim_range_select),
    .trim_fine_value      (trim_fine_value),
    .cmd_out              (cmd_out)
  );

  // ----------------------------------------------------------------
  // Clock, source oscillation and command pulse monitor
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (osc_run) begin
      source_osc <= ~source_osc;
    end
    if (cmd_out.valid === 1'b1) begin
      pulse_cnt <= pulse_cnt + 1;
      last_code <= cmd_out.code;
    end
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    $display("[FAIL] %0t run timeout", $time);
    finish_test();
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One Avalon transfer; a spare edge after release avoids re-raising
  // the strobe in the same time step
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    avs_req.read       <= ~wr;
    avs_req.write      <= wr;
    avs_req.address    <= a;
    avs_req.writedata  <= {24'h0, d};
    avs_req.byteenable <= 4'hf;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      num_errors++;
      $display("[FAIL] %0t bus timeout", $time);
      finish_test();
    end
    rd = avs_readdata;
    avs_req.read  <= 1'b0;
    avs_req.write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(rd, {24'h0, e});
  endtask

  task automatic unlock_wr(input logic [3:0] a, input logic [7:0] d);
    wr(a, UNLOCK_ONLY);
    wr(a, d);
  endtask

  task automatic do_reset(input logic f);
    divide_by_eight_fuse <= f;
    factory_trim         <= 8'(rnd());
    rstn                 <= 1'b0;
    cycles(16);
    rstn <= 1'b1;
    cycles(3);
    rd_chk(ADDR_TRIM, factory_trim);
    rd_chk(ADDR_DIV, f ? 8'h03 : 8'h00);
    rd_chk(ADDR_CMD, 8'h00);
    cur_div = f ? 4'h3 : 4'h0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    int p;
    int k;
    seed = 32'hf64933aa;
    rstn = 1'b0;
    avs_req = '0;
    divide_by_eight_fuse = 1'b1;
    factory_trim = 8'h00;
    running_source = 4'h1;
    source_osc = 1'b0;
    osc_run = 1'b0;
    last_code = 4'h0;
    num_errors = 0;
    total_checks = 0;
    pulse_cnt = 0;
    @(posedge sys_clk);
    do_reset(1'b0);
    do_reset(1'b1);
    tv = '{8'h7f, 8'h80, 8'(rnd()), 8'(rnd())};
    // No flash or EEPROM writes here, so any trim is safe
    foreach (tv[i]) begin
      wr(ADDR_TRIM, tv[i]);
      rd_chk(ADDR_TRIM, tv[i]);
      check({trim_range_select, trim_fine_value}, tv[i]);
    end
    wr(4'h2, 8'hff);
    rd_chk(4'h2, 8'h00);
    wr(ADDR_DIV, 8'h05);
    rd_chk(ADDR_DIV, {4'h0, cur_div});
    wr(ADDR_DIV, 8'h81);
    wr(ADDR_DIV, 8'h05);
    rd_chk(ADDR_DIV, {4'h0, cur_div});
    wr(ADDR_DIV, UNLOCK_ONLY);
    rd_chk(ADDR_DIV, {4'h8, cur_div});
    cycles(4);
    wr(ADDR_DIV, 8'h05);
    rd_chk(ADDR_DIV, {4'h0, cur_div});
    wr(ADDR_DIV, UNLOCK_ONLY);
    wr(ADDR_DIV, UNLOCK_ONLY);
    wr(ADDR_DIV, 8'h05);
    rd_chk(ADDR_DIV, {4'h0, cur_div});
    // Window of 512 cycles holds a whole number of divided periods
    for (int d = 0; d < 16; d++) begin
      p = 1 << cur_div;
      unlock_wr(ADDR_DIV, 8'(d));
      if (d <= 8) begin
        cur_div = 4'(d);
      end
      // Two ticks after the write: old period ends, first new one ends
      n = 0;
      k = 0;
      while (k < 2 && n < 600) begin
        @(posedge sys_clk);
        n++;
        if (div_tick === 1'b1) k++;
      end
      p = p + (1 << cur_div);
      check(n > (1 << cur_div) && n <= p, 1);
      rd_chk(ADDR_DIV, {4'h0, cur_div});
      cycles(800);
      n = 0;
      repeat (512) begin
        @(posedge sys_clk);
        if (div_tick === 1'b1) n++;
      end
      check(n, 32'd512 >> cur_div);
    end
    wr(ADDR_SRC, 8'h03);
    for (int c = 1; c < 16; c++) begin
      p = pulse_cnt;
      unlock_wr(ADDR_CMD, 8'(c));
      cycles(3);
      check(pulse_cnt - p, (c < 8) ? 1 : 0);
      if (c < 8) begin
        check({28'h0, last_code}, c);
        rd_chk(ADDR_CMD, 8'(c));
      end
    end
    rd_chk(ADDR_SRC, 8'h01);
    wr(ADDR_CMD, UNLOCK_ONLY);
    rd_chk(ADDR_CMD, 8'h8f);
    cycles(4);
    p = pulse_cnt;
    wr(ADDR_CMD, {4'h0, CMD_SWITCH});
    cycles(3);
    check(pulse_cnt - p, 0);
    p = pulse_cnt;
    wr(ADDR_CMD, UNLOCK_ONLY);
    wr(ADDR_CMD, UNLOCK_ONLY);
    wr(ADDR_CMD, {4'h0, CMD_SWITCH});
    cycles(3);
    check(pulse_cnt - p, 0);
    p = pulse_cnt;
    unlock_wr(ADDR_CMD, {4'h0, CMD_DISABLE});
    cycles(3);
    check(pulse_cnt - p, 0);
    // Source dead first, then oscillating; ready, then cleared by availability
    wr(ADDR_SRC, 8'h03);
    unlock_wr(ADDR_CMD, {4'h0, CMD_ENABLE});
    cycles(100);
    rd_chk(ADDR_CMD, 8'h02);
    osc_run <= 1'b1;
    n = 0;
    do begin
      bus(1'b0, ADDR_CMD, 8'h00);
      n++;
    end while (rd[READY_BIT] !== 1'b1 && n < 50);
    check(rd, 32'h12);
    osc_run <= 1'b0;
    unlock_wr(ADDR_CMD, {4'h0, CMD_AVAIL});
    rd_chk(ADDR_CMD, 8'h03);
    finish_test();
  end
endmodule
